/* supply_low_monitor.sv */
// Supply-low monitor: control register, comparator filtering, flag and recovery.
// Assumes comparators and trip voltages are analog, outside; the core reaches
// the register through its byte-wide special-function-register port.
`timescale 1ns/1ps
module supply_low_monitor
#(
  parameter int RECOVERY_CYCLES    = supply_watch_pkg::RECOVERY_CYCLES,
  parameter bit HIGH_VOLTAGE_PART  = 1'b0
)
(
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       reset,
  // Register port from the core
  input  wire supply_watch_pkg::sfr_req_t sfr_req,
  output logic [7:0]                      sfr_rdata,
  // Analog comparators
  input  wire logic                       digital_cmp_raw,
  input  wire logic                       analog_cmp_raw,
  output logic [1:0]                      digital_trip_select,
  output logic [1:0]                      analog_trip_select,
  output logic                            monitor_on,
  // Interrupt and reset requests
  input  wire logic                       interrupt_enable_secondary,
  output logic                            supply_irq,
  output logic                            por_request
);

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode, used by both read and write.
  function automatic logic sfr_hit(input logic [7:0] addr);
    if (addr == supply_watch_pkg::CONTROL_ADDR)
      sfr_hit = 1'b1;
    else
      sfr_hit = 1'b0;
  endfunction : sfr_hit

  ////////////////////////////////////////////////////////////////////////////////
  // Comparator filters.
  logic [1:0] cmp_raw;
  logic [1:0] cmp_ok;
  logic       digital_supply_compare;
  logic       analog_supply_compare;

  assign cmp_raw = {digital_cmp_raw, analog_cmp_raw};

  for (genvar i = 0; i < 2; i++)
  begin : g_filter
    supply_glitch_filter u_filter
    (
      .clk      (clk),
      .reset    (reset),
      .raw      (cmp_raw[i]),
      .filtered (cmp_ok[i])
    );
  end

  assign digital_supply_compare = cmp_ok[1];
  assign analog_supply_compare  = cmp_ok[0];

  ////////////////////////////////////////////////////////////////////////////////
  // Control register and flag.
  localparam logic [7:0] RST = supply_watch_pkg::CONTROL_RESET;
  localparam int         DT  = supply_watch_pkg::DIGITAL_TRIP_LO;
  localparam int         AT  = supply_watch_pkg::ANALOG_TRIP_LO;
  localparam logic [supply_watch_pkg::RECOVERY_W-1:0] RECOVERY_LAST =
    supply_watch_pkg::RECOVERY_W'(RECOVERY_CYCLES - 1);

  supply_watch_pkg::control_t                control;
  supply_watch_pkg::control_t                next_control;
  logic                                      supply_low_flag;
  logic                                      next_flag;
  logic [supply_watch_pkg::RECOVERY_W-1:0]   recovery;
  logic [supply_watch_pkg::RECOVERY_W-1:0]   next_recovery;
  logic [7:0]                                next_rdata;
  logic [7:0]                                status;
  logic                                      wr_hit;
  logic                                      rd_hit;
  logic                                      any_low;
  logic                                      fault;

  assign wr_hit  = sfr_req.wr && sfr_hit(sfr_req.addr);
  assign rd_hit  = sfr_req.rd && sfr_hit(sfr_req.addr);
  assign any_low = !digital_supply_compare || !analog_supply_compare;
  assign fault   = control.monitor_on && any_low;

  always_comb
  begin
    status = {digital_supply_compare, analog_supply_compare, supply_low_flag,
              control.digital_trip_select, control.analog_trip_select,
              control.monitor_on};
  end

  always_comb
  begin
    next_control  = control;
    next_flag     = supply_low_flag;
    next_recovery = '0;
    next_rdata    = 8'h00;
    if (wr_hit)
    begin
      next_control.digital_trip_select = sfr_req.wdata[DT+1:DT];
      next_control.analog_trip_select  = sfr_req.wdata[AT+1:AT];
      next_control.monitor_on = sfr_req.wdata[supply_watch_pkg::MONITOR_ON_BIT];
      // A clear is refused while either comparator still reads low.
      if (sfr_req.wdata[supply_watch_pkg::FLAG_BIT] || !any_low)
        next_flag = sfr_req.wdata[supply_watch_pkg::FLAG_BIT];
    end
    // Recovery runs only while enabled, flagged and both supplies good;
    // any relapse leaves the count at zero so the full interval restarts.
    if (control.monitor_on && supply_low_flag && !any_low)
    begin
      if (recovery == RECOVERY_LAST)
        next_flag = 1'b0;
      else
        next_recovery = recovery + 1'b1;
    end
    // Hardware set wins over a software clear in the same cycle.
    if (fault)
      next_flag = 1'b1;
    if (rd_hit)
      next_rdata = status;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      control.digital_trip_select <= RST[DT+1:DT];
      control.analog_trip_select  <= RST[AT+1:AT];
      control.monitor_on          <= RST[supply_watch_pkg::MONITOR_ON_BIT];
      supply_low_flag             <= RST[supply_watch_pkg::FLAG_BIT];
      recovery                    <= '0;
      sfr_rdata                   <= 8'h00;
    end
    else
    begin
      control         <= next_control;
      supply_low_flag <= next_flag;
      recovery        <= next_recovery;
      sfr_rdata       <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs to the analog side and the core.
  // The high-voltage part resets below its only trip level, so its digital
  // select is pinned to the top code and the comparator drives a reset request.
  assign digital_trip_select = HIGH_VOLTAGE_PART ? supply_watch_pkg::TRIP_4V63
                                                 : control.digital_trip_select;
  assign analog_trip_select  = control.analog_trip_select;
  assign monitor_on          = control.monitor_on;
  assign supply_irq          = supply_low_flag && interrupt_enable_secondary;
  assign por_request         = HIGH_VOLTAGE_PART && !digital_supply_compare;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  status_read_a: assert property (rd_hit |=> sfr_rdata[7:6] == $past(cmp_ok))
    else $error("status bits do not match filtered comparators");

  flag_set_a: assert property (fault |=> supply_low_flag)
    else $error("flag not set on a low supply");

  recovery_clear_a: assert property (
    supply_low_flag && control.monitor_on && !any_low && recovery == RECOVERY_LAST
    |=> !supply_low_flag)
    else $error("flag not cleared when recovery ran out");

  flag_hold_a: assert property (supply_low_flag && any_low |=> supply_low_flag)
    else $error("flag cleared while a supply is low");

  irq_gate_a: assert property (
    supply_irq == (supply_low_flag && interrupt_enable_secondary))
    else $error("interrupt not gated by enable");

  trip_write_a: assert property (wr_hit |=>
    (control.digital_trip_select == $past(sfr_req.wdata[DT+1:DT])) &&
    (control.analog_trip_select == $past(sfr_req.wdata[AT+1:AT])))
    else $error("trip selects did not take the write");

  por_link_a: assert property (
    por_request == (HIGH_VOLTAGE_PART && !digital_supply_compare))
    else $error("reset request does not follow digital comparator");

  enable_write_a: assert property (wr_hit |=>
    monitor_on == $past(sfr_req.wdata[supply_watch_pkg::MONITOR_ON_BIT]))
    else $error("enable bit did not take the write");

  relapse_restart_a: assert property (supply_low_flag && any_low |=> recovery == '0)
    else $error("recovery count not restarted on relapse");

  idle_counter_a: assert property (!control.monitor_on |=> recovery == '0)
    else $error("recovery counter ran while disabled");

  irq_raise_a: assert property (fault && interrupt_enable_secondary |=>
    supply_irq || !interrupt_enable_secondary)
    else $error("interrupt not raised on a low supply");

  soft_set_a: assert property (
    wr_hit && sfr_req.wdata[supply_watch_pkg::FLAG_BIT] && recovery != RECOVERY_LAST
    |=> supply_low_flag)
    else $error("software set of the flag was lost");

  soft_clear_a: assert property (
    wr_hit && !sfr_req.wdata[supply_watch_pkg::FLAG_BIT] && !any_low
    |=> !supply_low_flag)
    else $error("software clear refused with both supplies good");

  // A disabled monitor must stay quiet, or a part left off would still interrupt.
  disabled_quiet_a: assert property (
    !control.monitor_on && !supply_low_flag &&
    !(wr_hit && sfr_req.wdata[supply_watch_pkg::FLAG_BIT])
    |=> !supply_low_flag)
    else $error("flag set while the monitor was off");

  read_idle_a: assert property (!rd_hit |=> sfr_rdata == 8'h00)
    else $error("read data did not return to zero");

  flag_raised_c: cover property (!supply_low_flag ##1 supply_low_flag);
  auto_clear_c:  cover property (supply_low_flag && !any_low && !wr_hit ##1 !supply_low_flag);
  clear_refused_c: cover property (wr_hit && !sfr_req.wdata[supply_watch_pkg::FLAG_BIT]
                                   && any_low && supply_low_flag ##1 supply_low_flag);
  irq_raised_c:  cover property (!supply_irq ##1 supply_irq);
  relapse_c:     cover property (supply_low_flag && any_low && recovery != '0);

endmodule : supply_low_monitor

/* supply_watch_pkg.sv */
// Constants and types for the supply-low monitor and its control register.
// Assumes a 40 MHz core clock and a byte-wide special-function-register port.
package supply_watch_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map.
  localparam logic [7:0] CONTROL_ADDR  = 8'hdf;
  localparam logic [7:0] CONTROL_RESET = 8'hde;

  localparam int DIGITAL_OK_BIT  = 7;
  localparam int ANALOG_OK_BIT   = 6;
  localparam int FLAG_BIT        = 5;
  localparam int DIGITAL_TRIP_LO = 3;
  localparam int ANALOG_TRIP_LO  = 1;
  localparam int MONITOR_ON_BIT  = 0;

  // Trip-point codes, highest level first.
  localparam logic [1:0] TRIP_4V63 = 2'h0;
  localparam logic [1:0] TRIP_3V08 = 2'h1;
  localparam logic [1:0] TRIP_2V93 = 2'h2;
  localparam logic [1:0] TRIP_2V63 = 2'h3;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam longint CLK_HZ           = 40_000_000;
  localparam longint RECOVERY_TIME_MS = 250;
  localparam int     RECOVERY_CYCLES  = int'(RECOVERY_TIME_MS * CLK_HZ / 1000);
  localparam longint GLITCH_TIME_NS   = 1000;
  localparam int     GLITCH_CYCLES    = int'((GLITCH_TIME_NS * CLK_HZ + 999_999_999)
                                             / 1_000_000_000);
  localparam int     RECOVERY_W       = 24;
  localparam int     GLITCH_W         = 8;

  ////////////////////////////////////////////////////////////////////////////////
  // Types.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic [1:0] digital_trip_select;
    logic [1:0] analog_trip_select;
    logic       monitor_on;
  } control_t;

endpackage : supply_watch_pkg

/* supply_glitch_filter.sv */
// Three-stage synchroniser followed by a stability filter for one comparator.
// Assumes the comparator output is asynchronous to clk; idle level is high.
`timescale 1ns/1ps
module supply_glitch_filter
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Comparator
  input  wire logic raw,
  output logic      filtered
);

  logic [2:0]                                sync;
  logic [supply_watch_pkg::GLITCH_W-1:0]     count;
  logic [2:0]                                next_sync;
  logic [supply_watch_pkg::GLITCH_W-1:0]     next_count;
  logic                                      next_filtered;
  logic                                      settled;

  localparam logic [supply_watch_pkg::GLITCH_W-1:0] LAST =
    supply_watch_pkg::GLITCH_W'(supply_watch_pkg::GLITCH_CYCLES - 1);

  // Stage 0 feeds only stage 1; stages 1 and 2 are the agreeing pair.
  assign settled = (sync[1] == sync[2]) && (sync[2] != filtered);

  always_comb
  begin
    next_sync     = {sync[1:0], raw};
    next_count    = '0;
    next_filtered = filtered;
    if (settled)
    begin
      // A level must hold for the whole window before it is believed.
      if (count == LAST)
        next_filtered = sync[2];
      else
        next_count = count + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sync     <= 3'h7;
      count    <= '0;
      filtered <= 1'b1;
    end
    else
    begin
      sync     <= next_sync;
      count    <= next_count;
      filtered <= next_filtered;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  glitch_window_a: assert property ($changed(filtered) |-> $past(count) == LAST)
    else $error("filtered level changed before the window ran out");

endmodule : supply_glitch_filter

/* supply_comparator_model.sv */
// Behavioural model of the two analog supply comparators.
// Assumes supply levels are given as a rank: 4 is above every trip point, 0 below all.
`timescale 1ns/1ps
module supply_comparator_model
(
  // Supply ranks set by the bench
  input  wire logic [2:0] digital_level,
  input  wire logic [2:0] analog_level,
  // Trip selects from the monitor
  input  wire logic [1:0] digital_trip_select,
  input  wire logic [1:0] analog_trip_select,
  // Comparator results, 1 means above the trip point
  output logic            digital_cmp_raw,
  output logic            analog_cmp_raw
);
  // Code 00 is the highest trip point and 11 the lowest, so a lower code needs a higher rank.
  assign digital_cmp_raw = digital_level > (3'h3 - {1'b0, digital_trip_select});
  assign analog_cmp_raw  = analog_level > (3'h3 - {1'b0, analog_trip_select});
endmodule : supply_comparator_model

/* supply_low_monitor_flag_bench.sv */
// Self-checking bench for the supply-low monitor, with a high-voltage twin.
// Assumes the comparator model file is compiled first.
`timescale 1ns/1ps
module supply_low_monitor_flag_bench;
  logic                       clk;
  logic                       reset;
  supply_watch_pkg::sfr_req_t sfr_req;
  logic [7:0]                 sfr_rdata;
  logic                       dig_raw;
  logic                       ana_raw;
  logic [1:0]                 dig_sel;
  logic [1:0]                 ana_sel;
  logic [1:0]                 hv_sel;
  logic                       mon_on;
  logic                       ien;
  logic                       irq;
  logic                       por;
  logic                       hv_por;
  logic [2:0]                 dig_lvl;
  logic [2:0]                 ana_lvl;
  logic [7:0]                 d;
  int                         bad_count;
  int                         cmp_count;
  int                         cycles;

  ////////////////////////////////////////////////////////////////////////////////
  // A short recovery count keeps the run brief; it stays above the filter delay.
  supply_low_monitor #(.RECOVERY_CYCLES(60), .HIGH_VOLTAGE_PART(1'b0)) u_dut (
    .clk(clk), .reset(reset), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .digital_cmp_raw(dig_raw), .analog_cmp_raw(ana_raw), .digital_trip_select(dig_sel),
    .analog_trip_select(ana_sel), .monitor_on(mon_on), .interrupt_enable_secondary(ien),
    .supply_irq(irq), .por_request(por));
  supply_low_monitor #(.RECOVERY_CYCLES(60), .HIGH_VOLTAGE_PART(1'b1)) u_hv (
    .clk(clk), .reset(reset), .sfr_req(sfr_req), .sfr_rdata(),
    .digital_cmp_raw(dig_raw), .analog_cmp_raw(ana_raw), .digital_trip_select(hv_sel),
    .analog_trip_select(), .monitor_on(), .interrupt_enable_secondary(ien),
    .supply_irq(), .por_request(hv_por));
  supply_comparator_model u_cmp (
    .digital_level(dig_lvl), .analog_level(ana_lvl), .digital_trip_select(dig_sel),
    .analog_trip_select(ana_sel), .digital_cmp_raw(dig_raw), .analog_cmp_raw(ana_raw));

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    sfr_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk);
    sfr_req <= '0;
  endtask : wr_reg

  // Read data is registered, so it is sampled just after the edge that takes the strobe.
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    sfr_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    sfr_req <= '0;
    #1 v = sfr_rdata;
  endtask : rd_reg

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_cyc

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd_reg(8'hdf, d);
    check("reset value", d, 8'hde);
    check("monitor on", {7'h0, mon_on}, 8'h00);
    @(posedge clk);
    #1 check("read data idle", sfr_rdata, 8'h00);
    rd_reg(8'h55, d);
    check("unmapped read", d, 8'h00);
    wr_reg(8'h55, 8'h21);
    rd_reg(8'hdf, d);
    check("unmapped write", d, 8'hde);
  endtask : t_reset

  task automatic t_fields;
    for (int c = 0; c < 4; c++)
    begin
      wr_reg(8'hdf, {3'h0, 2'(c), 2'(c), 1'b1});
      #1;
      check("digital select", {6'h0, dig_sel}, 8'(c));
      check("analog select", {6'h0, ana_sel}, 8'(c));
      rd_reg(8'hdf, d);
      check("control read", d, {3'h6, 2'(c), 2'(c), 1'b1});
    end
    wr_reg(8'hdf, 8'h1e);
    #1 check("monitor off", {7'h0, mon_on}, 8'h00);
  endtask : t_fields

  task automatic t_disabled;
    dig_lvl <= 3'h0;
    wait_cyc(60);
    rd_reg(8'hdf, d);
    check("disabled status", d, 8'h5e);
    dig_lvl <= 3'h4;
    wait_cyc(60);
  endtask : t_disabled

  // Rank 2 is below the 01 trip point but above 10 and 11.
  task automatic t_fault;
    ien <= 1'b1;
    wr_reg(8'hdf, 8'h0b);
    dig_lvl <= 3'h2;
    wait_cyc(60);
    rd_reg(8'hdf, d);
    check("fault status", d, 8'h6b);
    check("irq on", {7'h0, irq}, 8'h01);
    @(posedge clk);
    ien <= 1'b0;
    @(posedge clk);
    #1 check("irq masked", {7'h0, irq}, 8'h00);
    @(posedge clk);
    ien <= 1'b1;
    wr_reg(8'hdf, 8'h0b);
    rd_reg(8'hdf, d);
    check("clear refused", d, 8'h6b);
    dig_lvl <= 3'h4;
    wait_cyc(50);
    dig_lvl <= 3'h2;
    wait_cyc(60);
    dig_lvl <= 3'h4;
    wait_cyc(80);
    rd_reg(8'hdf, d);
    check("recovery restarted", d, 8'heb);
    wait_cyc(40);
    rd_reg(8'hdf, d);
    check("recovered", d, 8'hcb);
    check("irq off", {7'h0, irq}, 8'h00);
  endtask : t_fault

  task automatic t_analog;
    ana_lvl <= 3'h0;
    wait_cyc(20);
    ana_lvl <= 3'h4;
    wait_cyc(60);
    rd_reg(8'hdf, d);
    check("glitch ignored", d, 8'hcb);
    ana_lvl <= 3'h2;
    wait_cyc(60);
    rd_reg(8'hdf, d);
    check("analog fault", d, 8'hab);
    ana_lvl <= 3'h4;
    wait_cyc(140);
    wr_reg(8'hdf, 8'h2b);
    rd_reg(8'hdf, d);
    check("software set", d, 8'heb);
    wr_reg(8'hdf, 8'h0b);
    rd_reg(8'hdf, d);
    check("software clear", d, 8'hcb);
  endtask : t_analog

  task automatic t_high_voltage;
    check("forced select", {6'h0, hv_sel}, 8'h00);
    dig_lvl <= 3'h0;
    wait_cyc(60);
    #1 check("por request", {7'h0, hv_por}, 8'h01);
    check("no por", {7'h0, por}, 8'h00);
    dig_lvl <= 3'h4;
  endtask : t_high_voltage

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    reset     = 1'b1;
    sfr_req   = '0;
    ien       = 1'b0;
    dig_lvl   = 3'h4;
    ana_lvl   = 3'h4;
    bad_count = 0;
    cmp_count = 0;
    cycles    = 0;
    wait_cyc(8);
    reset <= 1'b0;
    t_reset();
    t_fields();
    t_disabled();
    t_fault();
    t_analog();
    t_high_voltage();
    tally_and_finish();
  end
endmodule : supply_low_monitor_flag_bench
